// ### common/spims_defs.svh
// register offsets, field positions, reset values and timing counts of the serial block
`ifndef SPIMS_DEFS_SVH
`define SPIMS_DEFS_SVH
// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define SPIMS_IDX_DATA       10'h021
`define SPIMS_IDX_CTRL       10'h022
`define SPIMS_IDX_CSR        10'h023
// ************************************************************
// serial_control fields
// ************************************************************
`define SPIMS_CR_IRQ_EN      7
`define SPIMS_CR_PE          6
`define SPIMS_CR_RATE_DIV    5
`define SPIMS_CR_MASTER      4
`define SPIMS_CR_CLOCK_POLARITY        3
`define SPIMS_CR_CLOCK_PHASE        2
`define SPIMS_CR_RATE_HI     1
`define SPIMS_CR_RATE_LO     0
// ************************************************************
// serial_control_status fields
// ************************************************************
`define SPIMS_CSR_TC         7
`define SPIMS_CSR_WRITE_COLLISION_FLAG       6
`define SPIMS_CSR_OVR        5
`define SPIMS_CSR_MODE_FAULT_FLAG       4
`define SPIMS_CSR_SOD        2
`define SPIMS_CSR_SSM        1
`define SPIMS_CSR_SSI        0
// ************************************************************
// reset values
// ************************************************************
`define SPIMS_CTRL_RESET     8'h00
`define SPIMS_CSR_RESET      8'h00
`define SPIMS_DATA_RESET     8'h00
// ************************************************************
// timing: half serial clock period in cpu cycles per rate code
// ************************************************************
`define SPIMS_HALF_DIV4      7'h02
`define SPIMS_HALF_DIV8      7'h04
`define SPIMS_HALF_DIV16     7'h08
`define SPIMS_HALF_DIV32     7'h10
`define SPIMS_HALF_DIV64     7'h20
`define SPIMS_HALF_DIV128    7'h40
`define SPIMS_EDGES_PER_BYTE 5'h10
`endif

// ### common/spims_pkg.sv
// types shared by the serial block and its bench
package spims_pkg;
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } spims_pin_in_s;
   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
      logic ss_pin_used;
   } spims_pin_out_s;
endpackage

// ### hdl/spims_core.sv
// serial master/slave peripheral with apb register access
// Behaviour
// - irq_enable gates transfer-complete, mode-fault and overrun flags onto the interrupt.
// - peripheral_enable resets low; clear frees pins; master fault clears it.
// - master rate bits select cpu clock divided by 4 to 128.
// - rate bits are ignored while the block is a slave.
// - master_select drives clock out, swaps data pins; fault forces slave.
// - clock_polarity sets the idle level of the serial clock.
// - clock_phase zero samples on first edge, one on second edge.
// - upper four control bits clear at reset.
// - transfer complete sets at end; cleared by status read then data access.
// - data writes ignored while transfer complete set until status is read.
// - data write during a transfer sets write collision; cleared by software sequence.
// - overrun sets if a byte completes while flag set; status read clears.
// - mode fault on low select in master; control access then write clears.
// - output_disable disconnects the serial data output of the current role.
// - select_management ignores the select pin and uses internal_select.
// - internal_select zero selects, one deselects.
// - status register reads zero after reset.
// - master data write loads the shifter and starts a byte exchange.
// - received byte copied to buffer at completion; reads return the buffer.
// - after overrun the buffer keeps the first unread byte; later ones lost.
// - write collision never interrupts and leaves the transfer running.
// - fault clears enable and master; sets refused outside the clearing sequence.
`include "spims_defs.svh"
module spims_core #(
   parameter int ADDR_W = 12
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [ADDR_W-1:0]       paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   output logic                         irq,
   input  wire spims_pkg::spims_pin_in_s  pins_in,
   output spims_pkg::spims_pin_out_s      pins_out
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic       sck_d_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 4'hf;
         sync2_r <= 4'hf;
         sck_d_r <= 1'b1; // same level as the synchroniser so no false edge after reset
      end else begin
         sync1_r <= {pins_in.sck, pins_in.mosi, pins_in.miso, pins_in.ss_n};
         sync2_r <= sync1_r;
         sck_d_r <= sync2_r[3];
      end
   end
   logic sck_s;
   logic mosi_s;
   logic miso_s;
   logic ss_pin_s;
   assign sck_s    = sync2_r[3];
   assign mosi_s   = sync2_r[2];
   assign miso_s   = sync2_r[1];
   assign ss_pin_s = sync2_r[0];

   // ************************************************************
   // state
   // ************************************************************
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [7:0] csr_r;
   logic [7:0] csr_nxt;
   logic [7:0] rxbuf_r;
   logic [7:0] rxbuf_nxt;
   logic [7:0] sh_r;
   logic [7:0] sh_nxt;
   logic [7:0] rx_r;
   logic [7:0] rx_nxt;
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic [4:0] ecnt_r;
   logic [4:0] ecnt_nxt;
   logic       busy_r;
   logic       busy_nxt;
   logic       sck_r;
   logic       sck_nxt;
   logic       csr_seen_r;
   logic       csr_seen_nxt;
   logic       mode_fault_flag_arm_r;
   logic       mode_fault_flag_arm_nxt;

   // ************************************************************
   // decode and helpers
   // ************************************************************
   logic       acc;
   logic       wr;
   logic       rd;
   logic       sel_dr;
   logic       sel_cr;
   logic       sel_csr;
   logic       pe;
   logic       ms;
   logic       clock_phase;
   logic       ss_int_n;
   logic       slv_act;
   logic [6:0] half;
   logic       edge_ev;
   logic [4:0] e;
   logic       sample;
   logic       change;
   logic       done;
   logic [7:0] rx_v;

   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign rd      = acc & ~pwrite;
   assign sel_dr  = paddr[ADDR_W-1:2] == `SPIMS_IDX_DATA;
   assign sel_cr  = paddr[ADDR_W-1:2] == `SPIMS_IDX_CTRL;
   assign sel_csr = paddr[ADDR_W-1:2] == `SPIMS_IDX_CSR;
   assign pe      = ctrl_r[`SPIMS_CR_PE];
   assign ms      = ctrl_r[`SPIMS_CR_MASTER];
   assign clock_phase    = ctrl_r[`SPIMS_CR_CLOCK_PHASE];
   // software select replaces the pin entirely when managed internally
   assign ss_int_n = csr_r[`SPIMS_CSR_SSM] ? csr_r[`SPIMS_CSR_SSI] : ss_pin_s;
   assign slv_act  = pe & ~ms & ~ss_int_n;

   // rate decode only feeds the master divider, so slaves never see it
   always_comb begin
      unique case ({ctrl_r[`SPIMS_CR_RATE_DIV], ctrl_r[`SPIMS_CR_RATE_HI],
                    ctrl_r[`SPIMS_CR_RATE_LO]})
         3'h4:    half = `SPIMS_HALF_DIV4;
         3'h0:    half = `SPIMS_HALF_DIV8;
         3'h1:    half = `SPIMS_HALF_DIV16;
         3'h6:    half = `SPIMS_HALF_DIV32;
         3'h2:    half = `SPIMS_HALF_DIV64;
         3'h3:    half = `SPIMS_HALF_DIV128;
         default: half = `SPIMS_HALF_DIV128;
      endcase
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      ctrl_nxt     = ctrl_r;
      csr_nxt      = csr_r;
      rxbuf_nxt    = rxbuf_r;
      sh_nxt       = sh_r;
      rx_nxt       = rx_r;
      cnt_nxt      = cnt_r;
      ecnt_nxt     = ecnt_r;
      busy_nxt     = busy_r;
      sck_nxt      = sck_r;
      csr_seen_nxt = csr_seen_r;
      mode_fault_flag_arm_nxt = mode_fault_flag_arm_r;
      edge_ev      = 1'b0;
      e            = 5'h00;
      sample       = 1'b0;
      change       = 1'b0;
      done         = 1'b0;
      rx_v         = rx_r;

      // serial clock edges: own divider as master, synced pin as slave
      if (ms) begin
         if (busy_r) begin
            if (cnt_r == half - 7'h01) begin
               cnt_nxt = 7'h00;
               edge_ev = 1'b1;
            end else begin
               cnt_nxt = cnt_r + 7'h01;
            end
         end else begin
            sck_nxt = ctrl_r[`SPIMS_CR_CLOCK_POLARITY];
         end
      end else if (slv_act) begin
         edge_ev = sck_s ^ sck_d_r;
      end else begin
         // deselect mid-byte abandons the partial byte
         ecnt_nxt = 5'h00;
      end

      if (edge_ev) begin
         e        = ecnt_r + 5'h01;
         ecnt_nxt = e;
         if (ms) begin
            sck_nxt = ~sck_r;
         end
         sample = e[0] ^ clock_phase;
         change = ~sample & ~(clock_phase & (e == 5'h01)) & ~(~clock_phase & (e == `SPIMS_EDGES_PER_BYTE));
         if (sample) begin
            rx_v   = {rx_r[6:0], ms ? miso_s : mosi_s};
            rx_nxt = rx_v;
         end
         if (change) begin
            sh_nxt = {sh_r[6:0], 1'b0};
         end
         if (e == `SPIMS_EDGES_PER_BYTE) begin
            done     = 1'b1;
            ecnt_nxt = 5'h00;
            busy_nxt = 1'b0;
         end
      end

      // status read arms the clear sequences and drops overrun
      if (rd && sel_csr) begin
         csr_seen_nxt = 1'b1;
         csr_nxt[`SPIMS_CSR_OVR] = 1'b0;
      end
      if (wr && sel_csr) begin
         csr_nxt[`SPIMS_CSR_SOD] = pwdata[`SPIMS_CSR_SOD];
         csr_nxt[`SPIMS_CSR_SSM] = pwdata[`SPIMS_CSR_SSM];
         csr_nxt[`SPIMS_CSR_SSI] = pwdata[`SPIMS_CSR_SSI];
      end

      // data register access
      if (acc && sel_dr && csr_seen_r) begin
         csr_nxt[`SPIMS_CSR_TC]   = 1'b0;
         csr_nxt[`SPIMS_CSR_WRITE_COLLISION_FLAG] = 1'b0;
         csr_seen_nxt = 1'b0;
      end
      if (wr && sel_dr) begin
         if (csr_r[`SPIMS_CSR_TC] && !csr_seen_r) begin
            // write dropped silently
         end else if (busy_r || (slv_act && ecnt_r != 5'h00)) begin
            csr_nxt[`SPIMS_CSR_WRITE_COLLISION_FLAG] = 1'b1;
         end else begin
            sh_nxt = pwdata[7:0];
            if (ms && pe) begin
               busy_nxt = 1'b1;
               cnt_nxt  = 7'h00;
               ecnt_nxt = 5'h00;
            end
         end
      end

      // control register and the mode-fault clear sequence
      if (acc && sel_cr && csr_r[`SPIMS_CSR_MODE_FAULT_FLAG]) begin
         mode_fault_flag_arm_nxt = 1'b1;
      end
      if (wr && sel_cr) begin
         ctrl_nxt = pwdata[7:0];
         if (mode_fault_flag_arm_r) begin
            csr_nxt[`SPIMS_CSR_MODE_FAULT_FLAG] = 1'b0;
            mode_fault_flag_arm_nxt = 1'b0;
         end else if (csr_r[`SPIMS_CSR_MODE_FAULT_FLAG]) begin
            ctrl_nxt[`SPIMS_CR_PE]     = 1'b0;
            ctrl_nxt[`SPIMS_CR_MASTER] = 1'b0;
         end
      end

      // completion: set wins over any clear in the same cycle
      if (done) begin
         if (csr_r[`SPIMS_CSR_TC]) begin
            csr_nxt[`SPIMS_CSR_OVR] = 1'b1;
         end else begin
            rxbuf_nxt = rx_v;
         end
         csr_nxt[`SPIMS_CSR_TC] = 1'b1;
      end

      // mode fault: low select seen while enabled master
      if (pe && ms && !ss_int_n) begin
         csr_nxt[`SPIMS_CSR_MODE_FAULT_FLAG]   = 1'b1;
         ctrl_nxt[`SPIMS_CR_PE]     = 1'b0;
         ctrl_nxt[`SPIMS_CR_MASTER] = 1'b0;
         busy_nxt = 1'b0;
         ecnt_nxt = 5'h00;
         sck_nxt  = ctrl_r[`SPIMS_CR_CLOCK_POLARITY];
      end
      if (!pe) begin
         busy_nxt = 1'b0;
      end
      csr_nxt[3] = 1'b0;
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r     <= `SPIMS_CTRL_RESET;
         csr_r      <= `SPIMS_CSR_RESET;
         rxbuf_r    <= `SPIMS_DATA_RESET;
         sh_r       <= `SPIMS_DATA_RESET;
         rx_r       <= `SPIMS_DATA_RESET;
         cnt_r      <= 7'h00;
         ecnt_r     <= 5'h00;
         busy_r     <= 1'b0;
         sck_r      <= 1'b0;
         csr_seen_r <= 1'b0;
         mode_fault_flag_arm_r <= 1'b0;
      end else begin
         ctrl_r     <= ctrl_nxt;
         csr_r      <= csr_nxt;
         rxbuf_r    <= rxbuf_nxt;
         sh_r       <= sh_nxt;
         rx_r       <= rx_nxt;
         cnt_r      <= cnt_nxt;
         ecnt_r     <= ecnt_nxt;
         busy_r     <= busy_nxt;
         sck_r      <= sck_nxt;
         csr_seen_r <= csr_seen_nxt;
         mode_fault_flag_arm_r <= mode_fault_flag_arm_nxt;
      end
   end

   // ************************************************************
   // bus answer, interrupt and pins
   // ************************************************************
   always_comb begin
      prdata = 32'h0000_0000;
      if (sel_dr) begin
         prdata[7:0] = rxbuf_r;
      end else if (sel_cr) begin
         prdata[7:0] = ctrl_r;
      end else if (sel_csr) begin
         prdata[7:0] = csr_r;
      end
   end
   // zero wait states; unmapped words answer with an error
   assign pready  = 1'b1;
   assign pslverr = acc & ~(sel_dr | sel_cr | sel_csr);
   // write collision deliberately left out of the interrupt
   assign irq = ctrl_r[`SPIMS_CR_IRQ_EN] & (csr_r[`SPIMS_CSR_TC] | csr_r[`SPIMS_CSR_MODE_FAULT_FLAG] |
                                          csr_r[`SPIMS_CSR_OVR]);

   always_comb begin
      pins_out.sck_o       = (ms && busy_r) ? sck_r : ctrl_r[`SPIMS_CR_CLOCK_POLARITY];
      pins_out.sck_oe      = pe & ms;
      pins_out.mosi_o      = sh_r[7];
      pins_out.mosi_oe     = pe & ms & ~csr_r[`SPIMS_CSR_SOD];
      pins_out.miso_o      = sh_r[7];
      pins_out.miso_oe     = slv_act & ~csr_r[`SPIMS_CSR_SOD];
      pins_out.ss_pin_used = pe & ~csr_r[`SPIMS_CSR_SSM];
   end
endmodule // spims_core

// ### testbench/spims_slave_model.sv
// far-side serial slave model: shifts a byte out on miso and collects mosi
module spims_slave_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       clock_phase,
   input  wire logic       arm,
   input  wire logic [7:0] tx,
   output logic            miso,
   output logic [7:0]      rx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       sck_q_r;
   logic       last_r;
   logic [4:0] edge_r;
   logic [2:0] idx;
   // output bit moves on the shift edge of the phase the master uses
   assign idx = (clock_phase && edge_r != 5'h00) ? 3'((edge_r - 5'h01) >> 1) : 3'(edge_r >> 1);
   // outside a frame the line toggles, so a stale bit is never mistaken for data
   assign miso = (edge_r < 5'h10) ? tx[3'h7 - idx] : ~last_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_q_r <= 1'b0;
         last_r  <= 1'b0;
         edge_r  <= 5'h10;
         rx      <= 8'h00;
      end else begin
         sck_q_r <= sck;
         last_r  <= miso;
         if (arm) begin
            edge_r <= 5'h00;
         end else if (sck != sck_q_r && edge_r < 5'h10) begin
            edge_r <= edge_r + 5'h01;
            if (edge_r[0] == clock_phase) begin
               rx <= {rx[6:0], mosi};
            end
         end
      end
   end
endmodule // spims_slave_model

// ### testbench/spims_core_monitor.sv
// port-level checker of the serial block, bound to its top module
`include "spims_defs.svh"
module spims_monitor #(
   parameter int ADDR_W = 12
) (
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [ADDR_W-1:0]         paddr,
   input wire logic [31:0]               pwdata,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire logic                      irq,
   input wire spims_pkg::spims_pin_in_s  pins_in,
   input wire spims_pkg::spims_pin_out_s pins_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [ADDR_W-1:0] A_D = ADDR_W'({`SPIMS_IDX_DATA, 2'b00});
   localparam logic [ADDR_W-1:0] A_C = ADDR_W'({`SPIMS_IDX_CTRL, 2'b00});
   localparam logic [ADDR_W-1:0] A_S = ADDR_W'({`SPIMS_IDX_CSR, 2'b00});
   spims_pkg::spims_pin_out_s po;
   logic                      wc;
   logic                      ws;
   logic [4:0]                cnt_r;
   assign po = pins_out;
   assign wc = psel && penable && pwrite && paddr == A_C;
   assign ws = psel && penable && pwrite && paddr == A_S;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ********************
   // serial clock edges since the last data write
   // ********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 5'h00;
      end else if (psel && penable && pwrite && paddr == A_D) begin
         cnt_r <= 5'h00;
      end else if (po.sck_oe && $past(po.sck_oe) && $changed(po.sck_o)) begin
         cnt_r <= cnt_r + 5'h01;
      end
   end
   property p_irq_off; wc && !pwdata[7] |=> !irq; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
   property p_pe_off;
      wc && !pwdata[6] |=> !po.sck_oe && !po.mosi_oe && !po.miso_oe && !po.ss_pin_used;
   endproperty
   a_pe_off: assert property (p_pe_off) else $error("pins held while disabled");
   property p_half;
      po.sck_oe && $past(po.sck_oe) && $changed(po.sck_o) |=> !po.sck_oe || $stable(po.sck_o);
   endproperty
   a_half: assert property (p_half) else $error("serial clock half period too short");
   property p_roles; !(po.mosi_oe && (po.miso_oe || !po.sck_oe)); endproperty
   a_roles: assert property (p_roles) else $error("data pin roles wrong");
   property p_idle;
      wc && pwdata[6] && pwdata[4] && !po.sck_oe |=> po.sck_oe && po.sck_o == $past(pwdata[3]);
   endproperty
   a_idle: assert property (p_idle) else $error("serial clock idle level wrong");
   property p_sod; ws && pwdata[2] |=> !po.mosi_oe && !po.miso_oe; endproperty
   a_sod: assert property (p_sod) else $error("data output not disabled");
   property p_fault;
      !pins_in.ss_n && po.ss_pin_used && po.sck_oe |-> ##[1:4] !po.sck_oe;
   endproperty
   a_fault: assert property (p_fault) else $error("master kept on with select low");
   property p_bits; cnt_r <= 5'h10; endproperty
   a_bits: assert property (p_bits) else $error("more than eight bits shifted");
endmodule // spims_monitor
bind spims_core spims_monitor #(.ADDR_W(ADDR_W)) u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq(irq), .pins_in(pins_in), .pins_out(pins_out));

// ### testbench/tb_spi_master_slave_regs.sv
// self-checking bench of the serial block: apb tasks, transfers and a mode fault
`include "spims_defs.svh"
module tb_spi_master_slave_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] A_D = {`SPIMS_IDX_DATA, 2'b00};
   localparam logic [11:0] A_C = {`SPIMS_IDX_CTRL, 2'b00};
   localparam logic [11:0] A_S = {`SPIMS_IDX_CSR, 2'b00};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd_r;
   logic        pready, pslverr, irq, err_r, miso_w;
   logic        ss_n_r = 1'b1, clock_phase_r = 1'b0, arm_r = 1'b0;
   logic        m_sck_r = 1'b0, m_mosi_r = 1'b0, slv_r = 1'b0;
   logic [7:0]  tx_r = 8'h00, rx_w;
   logic [7:0]  mtx = 8'h69, stx = 8'ha5;
   logic [7:0]  cfg [6] = '{8'hf0, 8'hd4, 8'hd9, 8'hfe, 8'hd2, 8'hdf};
   int          dv [6] = '{4, 8, 16, 32, 64, 128};
   int          n_fail = 0, compares = 0, n;
   spims_pkg::spims_pin_in_s  pins_in;
   spims_pkg::spims_pin_out_s po;
   // a released mosi line shows the inverse of the design's output; in slave mode the bench is master
   assign pins_in = '{sck: po.sck_oe ? po.sck_o : m_sck_r,
                      mosi: po.mosi_oe ? po.mosi_o : (slv_r ? m_mosi_r : ~po.mosi_o),
                      miso: po.miso_oe ? po.miso_o : miso_w, ss_n: ss_n_r};
   spims_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .pins_in(pins_in), .pins_out(po));
   spims_slave_model u_slv (.pclk(pclk), .presetn(presetn), .sck(po.sck_o),
      .mosi(pins_in.mosi), .clock_phase(clock_phase_r), .arm(arm_r), .tx(tx_r), .miso(miso_w), .rx(rx_w));
   always #4 pclk = ~pclk;
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_r = prdata;
      err_r = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rd_r, {24'h0, exp});
   endtask
   task automatic wait_irq();
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (irq !== 1'b1 && n < 3000);
      if (irq !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t no interrupt", $time);
      end
   endtask
   // polarity only changes with the block disabled, as software must
   task automatic start(input logic [7:0] c, input logic [7:0] d, input logic [7:0] s);
      apb(1'b1, A_C, 8'h00);
      clock_phase_r <= c[2];
      tx_r <= s;
      apb(1'b1, A_C, c);
      #1;
      chk({31'h0, po.sck_o}, {31'h0, c[3]});
      arm_r <= 1'b1;
      apb(1'b1, A_D, d);
      arm_r <= 1'b0;
   endtask
   task automatic give_verdict();
      if (n_fail == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200us;
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_C, 8'h00);
      rd(A_S, 8'h00);
      apb(1'b0, 12'h090, 8'h00);
      chk({31'h0, err_r}, 32'h1);
      apb(1'b1, A_S, 8'h03);
      for (int i = 0; i < 6; i++) begin
         start(cfg[i], 8'h96 ^ 8'(i * 17), 8'h3c + 8'(i * 37));
         wait_irq();
         chk(32'(n >= 8 * dv[i] + 1 && n <= 8 * dv[i] + 3), 32'h1);
         rd(A_S, 8'h83);
         apb(1'b0, A_D, 8'h00);
         if (dv[i] > 4) chk(rd_r, {24'h0, 8'h3c + 8'(i * 37)});
         chk({24'h0, rx_w}, {24'h0, 8'h96 ^ 8'(i * 17)});
         rd(A_S, 8'h03);
      end
      start(8'hd0, 8'h5a, 8'hc6);
      apb(1'b1, A_D, 8'h11);
      #1;
      chk({31'h0, irq}, 32'h0);
      wait_irq();
      arm_r <= 1'b1;
      @(posedge pclk);
      arm_r <= 1'b0;
      apb(1'b1, A_D, 8'h22);
      repeat (80) @(posedge pclk);
      chk({24'h0, rx_w}, 32'h5a);
      rd(A_S, 8'hc3);
      rd(A_D, 8'hc6);
      rd(A_S, 8'h03);
      apb(1'b1, A_C, 8'h00);
      apb(1'b1, A_S, 8'h00);
      apb(1'b1, A_C, 8'hd0);
      apb(1'b1, A_S, 8'h04);
      #1;
      chk({31'h0, po.mosi_oe}, 32'h0);
      apb(1'b1, A_S, 8'h00);
      #1;
      chk({30'h0, po.mosi_oe, po.ss_pin_used}, 32'h3);
      ss_n_r <= 1'b0;
      repeat (6) @(posedge pclk);
      ss_n_r <= 1'b1;
      rd(A_S, 8'h10);
      chk({31'h0, irq}, 32'h1);
      rd(A_C, 8'h80);
      apb(1'b1, A_C, 8'hd0);
      rd(A_S, 8'h00);
      rd(A_C, 8'hd0);
      apb(1'b1, A_C, 8'h00);
      #1;
      chk({30'h0, po.sck_oe, po.ss_pin_used}, 32'h0);
      // slave byte: bench clocks phase zero, rate bits set but unused
      apb(1'b1, A_S, 8'h02);
      apb(1'b1, A_C, 8'hc3);
      apb(1'b1, A_D, stx);
      slv_r <= 1'b1;
      for (int b = 7; b >= 0; b--) begin
         m_mosi_r <= mtx[b];
         repeat (8) @(posedge pclk);
         chk({31'h0, pins_in.miso}, {31'h0, stx[b]});
         m_sck_r <= 1'b1;
         repeat (8) @(posedge pclk);
         m_sck_r <= 1'b0;
      end
      repeat (4) @(posedge pclk);
      rd(A_S, 8'h82);
      chk({31'h0, irq}, 32'h1);
      rd(A_D, 8'h69);
      give_verdict();
   end
endmodule // tb_spi_master_slave_regs
